// >>> hw/sbsr_top.sv
// status byte, service request mask and service request generation
//
// Function
// - status query or serial poll returns current status byte contents.
// - mask bit pairs with each status bit; mask bit 6 never matters.
// - enabled status bit rising 0 to 1 raises a service request.
// - mask-set command loads the mask; mask query returns it.
// - bit 1 mirrors the device status register summary.
// - bit 2 set while error queue non-empty; each new error requests service if mask bit 2 is set.
// - bit 3 is the questionable register summary.
// - bit 4 set while output queue holds a readable response.
// - bit 5 is the standard event register summary.
// - bit 6 is master summary of other enabled set bits.
// - bit 7 is the operation register summary.
// - lower registers summarise by or of event and enable pairs.
`timescale 1ns/1ns
`include "sbsr_regs.svh"
`default_nettype none

module sbsr_top (
	// clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_reset_n,
	// lower-level status registers
	input  wire sbsr_pkg::sbsr_lower_t i_lower [`SBSR_SRC_COUNT],
	// queue states
	input  wire logic                 i_error_queue_nonempty,
	input  wire logic                 i_error_push,
	input  wire logic                 i_output_queue_ready,
	// commands from the controller
	input  wire logic                 i_status_query,
	input  wire logic                 i_serial_poll,
	input  wire logic                 i_mask_write,
	input  wire logic [7:0]           i_mask_data,
	input  wire logic                 i_mask_query,
	// answers and request
	output logic                      o_reply_valid,
	output logic [7:0]                o_reply_data,
	output logic [7:0]                o_status_summary_byte,
	output logic [7:0]                o_service_request_mask,
	output logic                      o_service_request,
	output logic                      o_request_pulse
);

	// pick one query per cycle, serial poll first
	function automatic sbsr_pkg::sbsr_query_t pick_query(input logic poll,
		input logic stat, input logic mask);
		if (poll) begin
			pick_query = sbsr_pkg::SBSR_Q_POLL;
		end else if (stat) begin
			pick_query = sbsr_pkg::SBSR_Q_STATUS;
		end else if (mask) begin
			pick_query = sbsr_pkg::SBSR_Q_MASK;
		end else begin
			pick_query = sbsr_pkg::SBSR_Q_NONE;
		end
	endfunction

	logic [`SBSR_SRC_COUNT-1:0] summary;
	logic [7:0]                 status_summary_byte_reg;
	logic [7:0]                 status_summary_byte_next;
	logic [7:0]                 service_request_mask_reg;
	logic [7:0]                 service_request_mask_next;
	logic                       request_reg;
	logic                       request_next;
	logic                       pulse_reg;
	logic                       pulse_next;
	sbsr_pkg::sbsr_reply_t      reply_reg;
	sbsr_pkg::sbsr_reply_t      reply_next;
	logic [7:0]                 rise;
	logic                       raise;
	logic                       master_summary_flag;
	logic                       message_available_flag;
	logic                       standard_event_summary;
	sbsr_pkg::sbsr_query_t      query;

	// summary bit of each lower-level register
	genvar s;
	generate
		for (s = 0; s < `SBSR_SRC_COUNT; s++) begin : g_sum
			sbsr_summary u_sum (
				.i_lower   (i_lower[s]),
				.o_summary (summary[s])
			);
		end
	endgenerate

	assign message_available_flag = i_output_queue_ready;
	assign standard_event_summary = summary[`SBSR_SRC_STDEV];

	// next status byte from the lower levels and queues
	always_comb begin
		status_summary_byte_next = `SBSR_STB_RESET;
		status_summary_byte_next[`SBSR_BIT_UNUSED] = 1'b0;
		status_summary_byte_next[`SBSR_BIT_DEVICE] = summary[`SBSR_SRC_DEVICE];
		status_summary_byte_next[`SBSR_BIT_ERRQ]   = i_error_queue_nonempty;
		status_summary_byte_next[`SBSR_BIT_QUEST]  = summary[`SBSR_SRC_QUEST];
		status_summary_byte_next[`SBSR_BIT_MSGAV]  = message_available_flag;
		status_summary_byte_next[`SBSR_BIT_STDEV]  = standard_event_summary;
		status_summary_byte_next[`SBSR_BIT_OPER]   = summary[`SBSR_SRC_OPER];
		// master bit ignores mask bit 6 and bit 0
		master_summary_flag = |(status_summary_byte_next & service_request_mask_reg
			& `SBSR_REQ_BITS);
		status_summary_byte_next[`SBSR_BIT_MASTER] = master_summary_flag;
	end

	// status byte register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			status_summary_byte_reg <= `SBSR_STB_RESET;
		end else begin
			status_summary_byte_reg <= status_summary_byte_next;
		end
	end

	// mask load from the mask-set command
	always_comb begin
		service_request_mask_next = service_request_mask_reg;
		if (i_mask_write) begin
			service_request_mask_next = i_mask_data;
		end
	end

	// mask register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			service_request_mask_reg <= `SBSR_MASK_RESET;
		end else begin
			service_request_mask_reg <= service_request_mask_next;
		end
	end

	// request on enabled rising bit or on each new error while mask bit 2 is set; poll clears, set wins
	always_comb begin
		rise  = status_summary_byte_next & ~status_summary_byte_reg;
		raise = (|(rise & service_request_mask_reg & `SBSR_REQ_BITS))
			| (i_error_push & service_request_mask_reg[`SBSR_BIT_ERRQ]);
		request_next = request_reg;
		if (i_serial_poll) begin
			request_next = 1'b0;
		end
		if (raise) begin
			request_next = 1'b1;
		end
		pulse_next = raise;
	end

	// request registers
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			request_reg <= 1'b0;
			pulse_reg   <= 1'b0;
		end else begin
			request_reg <= request_next;
			pulse_reg   <= pulse_next;
		end
	end

	// answer to queries
	always_comb begin
		query = pick_query(i_serial_poll, i_status_query, i_mask_query);
		reply_next.valid = 1'b1;
		reply_next.data  = 8'h00;
		case (query)
			sbsr_pkg::SBSR_Q_POLL: begin
				reply_next.data = status_summary_byte_reg;
			end
			sbsr_pkg::SBSR_Q_STATUS: begin
				reply_next.data = status_summary_byte_reg;
			end
			sbsr_pkg::SBSR_Q_MASK: begin
				reply_next.data = service_request_mask_reg;
			end
			default: begin
				reply_next.valid = 1'b0;
			end
		endcase
	end

	// reply register
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reply_reg <= '0;
		end else begin
			reply_reg <= reply_next;
		end
	end

	// outputs
	assign o_reply_valid          = reply_reg.valid;
	assign o_reply_data           = reply_reg.data;
	assign o_status_summary_byte  = status_summary_byte_reg;
	assign o_service_request_mask = service_request_mask_reg;
	assign o_service_request      = request_reg;
	assign o_request_pulse        = pulse_reg;

	// status query answered with the status byte one cycle later
	chk_status_query_reply: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_status_query && !i_serial_poll) |=> (o_reply_valid
			&& o_reply_data == $past(status_summary_byte_reg)))
		else $error("status query reply wrong");

	// serial poll answered with the status byte
	chk_poll_reply: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_serial_poll |=> (o_reply_valid && o_reply_data == $past(status_summary_byte_reg)))
		else $error("serial poll reply wrong");

	// mask write, one idle cycle, then a lone mask query returns the written value
	chk_mask_roundtrip: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_mask_write ##1 !i_mask_write
			##1 (i_mask_query && !i_serial_poll && !i_status_query && !i_mask_write))
			|=> (o_reply_data == $past(i_mask_data, 3)))
		else $error("mask query does not return written mask");

	// bit 0 stays zero
	chk_bit0_zero: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		!o_status_summary_byte[`SBSR_BIT_UNUSED])
		else $error("status bit 0 set");

	// master bit equals enabled other bits
	chk_master_summary: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_status_summary_byte[`SBSR_BIT_MASTER] == |(o_status_summary_byte
			& $past(service_request_mask_reg) & `SBSR_REQ_BITS))
		else $error("master summary mismatch");

	// enabled bit seen rising in the byte comes with a request in the same cycle
	chk_rise_request: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(|(o_status_summary_byte & ~$past(o_status_summary_byte)
			& $past(service_request_mask_reg) & `SBSR_REQ_BITS))
			|-> (o_service_request && o_request_pulse))
		else $error("enabled rising bit gave no request");

	// new error with bit 2 enabled always requests
	chk_error_request: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_error_push && service_request_mask_reg[`SBSR_BIT_ERRQ]) |=> o_request_pulse)
		else $error("queued error gave no request");

	// mask bit 6 alone never requests
	chk_mask6_ignored: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(!(|(rise & service_request_mask_reg & `SBSR_REQ_BITS)) && !i_error_push)
			|=> !o_request_pulse)
		else $error("request without enabled cause");

	// bit 4 follows output queue with one cycle delay
	chk_msg_available: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_status_summary_byte[`SBSR_BIT_MSGAV] == $past(i_output_queue_ready))
		else $error("message available bit wrong");

	// bit 5 follows the standard event summary
	chk_stdev_bit: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_status_summary_byte[`SBSR_BIT_STDEV] == $past(summary[`SBSR_SRC_STDEV]))
		else $error("standard event bit wrong");

	// bit 7 follows the operation summary, bit 1 the device summary
	chk_oper_device: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(o_status_summary_byte[`SBSR_BIT_OPER] == $past(summary[`SBSR_SRC_OPER]))
		&& (o_status_summary_byte[`SBSR_BIT_DEVICE] == $past(summary[`SBSR_SRC_DEVICE])))
		else $error("operation or device bit wrong");

	// bit 3 follows the questionable summary
	chk_quest_bit: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_status_summary_byte[`SBSR_BIT_QUEST] == $past(|(i_lower[`SBSR_SRC_QUEST].event_bits
			& i_lower[`SBSR_SRC_QUEST].enable_bits)))
		else $error("questionable bit wrong");

endmodule

`default_nettype wire

// >>> hw/sbsr_regs.svh
// constants for the status byte and service request block
`ifndef SBSR_REGS_SVH
`define SBSR_REGS_SVH

// status byte bit positions
`define SBSR_BIT_UNUSED   0
`define SBSR_BIT_DEVICE   1
`define SBSR_BIT_ERRQ     2
`define SBSR_BIT_QUEST    3
`define SBSR_BIT_MSGAV    4
`define SBSR_BIT_STDEV    5
`define SBSR_BIT_MASTER   6
`define SBSR_BIT_OPER     7

// lower-level register slots feeding the status byte
`define SBSR_SRC_DEVICE   0
`define SBSR_SRC_QUEST    1
`define SBSR_SRC_STDEV    2
`define SBSR_SRC_OPER     3
`define SBSR_SRC_COUNT    4

// reset values
`define SBSR_MASK_RESET   8'h00
`define SBSR_STB_RESET    8'h00

// bits that may raise a request: all but unused bit 0 and master bit 6
`define SBSR_REQ_BITS     8'hBE

`endif

// >>> hw/sbsr_pkg.sv
// types for the status byte and service request block
package sbsr_pkg;

	// one lower-level status register: event part and enable part
	typedef struct packed {
		logic [15:0] event_bits;
		logic [15:0] enable_bits;
	} sbsr_lower_t;

	// answer to a query or serial poll
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} sbsr_reply_t;

	// query selected in a cycle
	typedef enum logic [1:0] {
		SBSR_Q_NONE,
		SBSR_Q_POLL,
		SBSR_Q_STATUS,
		SBSR_Q_MASK
	} sbsr_query_t;

endpackage

// >>> hw/sbsr_summary.sv
// summary bit of one lower-level status register
`timescale 1ns/1ns
`default_nettype none

module sbsr_summary (
	// lower register parts
	input  wire sbsr_pkg::sbsr_lower_t i_lower,
	// summary output
	output logic                       o_summary
);

	logic [15:0] gated;

	// each event bit anded with its enable bit
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_gate
			assign gated[g] = i_lower.event_bits[g] & i_lower.enable_bits[g];
		end
	endgenerate

	// or of all gated bits forms the summary
	assign o_summary = |gated;

endmodule

`default_nettype wire

// >>> tb/sbsr_ctrl_model.sv
// remote controller model issuing commands to the status block
`timescale 1ns/1ns
`default_nettype none

module sbsr_ctrl_model (
	// clock
	input  wire logic       i_clock,
	// command strobes and mask data
	output logic            o_status_query,
	output logic            o_serial_poll,
	output logic            o_mask_write,
	output logic            o_mask_query,
	output logic [7:0]      o_mask_data
);
	// idle at time zero
	initial begin
		o_status_query = 1'b0;
		o_serial_poll  = 1'b0;
		o_mask_write   = 1'b0;
		o_mask_query   = 1'b0;
		o_mask_data    = 8'h00;
	end

	// one strobe for one clock: 1 status, 2 poll, 3 mask write, 4 mask query
	task automatic send(input int kind, input logic [7:0] data);
		@(posedge i_clock);
		o_status_query <= (kind == 1);
		o_serial_poll  <= (kind == 2);
		o_mask_write   <= (kind == 3);
		o_mask_query   <= (kind == 4);
		o_mask_data    <= data;
		@(posedge i_clock);
		o_status_query <= 1'b0;
		o_serial_poll  <= 1'b0;
		o_mask_write   <= 1'b0;
		o_mask_query   <= 1'b0;
		o_mask_data    <= ~data; // released data never holds the old value
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the status byte and service request block
`timescale 1ns/1ns
`include "sbsr_regs.svh"
`default_nettype none

module tb_top;
	typedef struct packed {
		logic [7:0] mask;
		logic [3:0] ev;
		logic [3:0] en;
		logic       errq;
		logic       outq;
		logic [7:0] stb;
	} sbsr_row_t;

	logic                  clock = 1'b0;
	logic                  reset_n = 1'b0;
	sbsr_pkg::sbsr_lower_t lower [`SBSR_SRC_COUNT];
	logic                  errq = 1'b0;
	logic                  push = 1'b0;
	logic                  outq = 1'b0;
	logic                  sq, sp, mw, mq;
	logic [7:0]            md, reply_data, stb, mask;
	logic                  reply_valid, srq, req_pulse;
	int                    n_errors = 0;
	int                    checked = 0;
	int                    cycles = 0;
	logic                  exp_req;
	sbsr_row_t rows [8] = '{
		'{8'h10, 4'h0, 4'h0, 1'b0, 1'b1, 8'h50},
		'{8'h02, 4'h1, 4'h1, 1'b0, 1'b0, 8'h42},
		'{8'h08, 4'h2, 4'h0, 1'b0, 1'b0, 8'h00},
		'{8'h08, 4'h2, 4'h2, 1'b0, 1'b0, 8'h48},
		'{8'h20, 4'h4, 4'h4, 1'b0, 1'b0, 8'h60},
		'{8'h80, 4'h8, 4'h8, 1'b0, 1'b0, 8'hC0},
		'{8'h04, 4'h0, 4'h0, 1'b1, 1'b0, 8'h44},
		'{8'h41, 4'hF, 4'hF, 1'b1, 1'b1, 8'hBE}};

	// 125 MHz clock
	always #4 clock = ~clock;

	sbsr_ctrl_model u_ctl (.i_clock(clock), .o_status_query(sq), .o_serial_poll(sp),
		.o_mask_write(mw), .o_mask_query(mq), .o_mask_data(md));

	sbsr_top u_dut (.i_clock(clock), .i_reset_n(reset_n), .i_lower(lower),
		.i_error_queue_nonempty(errq), .i_error_push(push), .i_output_queue_ready(outq),
		.i_status_query(sq), .i_serial_poll(sp), .i_mask_write(mw), .i_mask_data(md),
		.i_mask_query(mq), .o_reply_valid(reply_valid), .o_reply_data(reply_data),
		.o_status_summary_byte(stb), .o_service_request_mask(mask),
		.o_service_request(srq), .o_request_pulse(req_pulse));

	// verdict and end of run
	task automatic final_report();
		if (n_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// compare seen against expected
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
		end
	endtask

	// drive the lower registers at event bit 3 and the queue levels
	task automatic drive(input logic [3:0] ev, input logic [3:0] en, input logic eq,
		input logic oq);
		@(posedge clock);
		for (int k = 0; k < `SBSR_SRC_COUNT; k++) begin
			lower[k] <= {12'h000, ev[k], 3'h0, 12'h000, en[k], 3'h0};
		end
		errq <= eq;
		outq <= oq;
	endtask

	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_errors++;
			final_report();
		end
	end

	// main sequence
	initial begin
		foreach (lower[k]) lower[k] = '0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		#1;
		check(stb, 8'h00);
		check({7'h00, srq}, 8'h00);
		u_ctl.send(4, 8'h00);
		#1;
		check(reply_data, 8'h00);
		check({7'h00, reply_valid}, 8'h01);
		// table rows: mask, sources, expected byte and request
		foreach (rows[r]) begin
			drive(4'h0, 4'h0, 1'b0, 1'b0);
			u_ctl.send(3, rows[r].mask);
			drive(rows[r].ev, rows[r].en, rows[r].errq, rows[r].outq);
			@(posedge clock);
			#1;
			check(stb, rows[r].stb);
			check(mask, rows[r].mask);
			exp_req = |(rows[r].stb & rows[r].mask & `SBSR_REQ_BITS);
			check({7'h00, req_pulse}, {7'h00, exp_req});
			check({7'h00, srq}, {7'h00, exp_req});
			u_ctl.send(2, 8'h00);
			#1;
			check(reply_data, rows[r].stb);
			check({7'h00, srq}, 8'h00);
		end
		// with mask bit 2 set, every queued error requests service, even with bit 2 already set
		drive(4'h0, 4'h0, 1'b0, 1'b0);
		u_ctl.send(3, 8'h04);
		drive(4'h0, 4'h0, 1'b1, 1'b0);
		@(posedge clock);
		#1;
		check({7'h00, req_pulse}, 8'h01);
		@(posedge clock);
		push <= 1'b1;
		#1;
		check({7'h00, req_pulse}, 8'h00);
		@(posedge clock);
		push <= 1'b0;
		#1;
		check({7'h00, req_pulse}, 8'h01);
		check({7'h00, srq}, 8'h01);
		u_ctl.send(1, 8'h00);
		#1;
		check(reply_data, 8'h44);
		// mask write then mask query; the reply stands one cycle only
		u_ctl.send(3, 8'hA5);
		u_ctl.send(4, 8'h00);
		#1;
		check(reply_data, 8'hA5);
		@(posedge clock);
		#1;
		check({7'h00, reply_valid}, 8'h00);
		// second reset in mid-run clears the mask
		@(posedge clock);
		reset_n <= 1'b0;
		#1;
		check(mask, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
